// [verilog/csr_core_regs.sv]
// Functional notes
// - Flag-updating instruction writing status: written result flags ignored, result used.
// - Watchdog expiry and sleep flags are read only.
// - Indirect bank select picks 100h-1FFh when 1, 00h-FFh when 0.
// - Direct bank select picks one of four 128-byte banks.
// - Expiry flag set by power-up, watchdog clear, sleep; cleared by time-out.
// - Sleep flag set by power-up and watchdog clear; cleared by sleep.
// - Zero flag set on zero result, cleared otherwise.
// - Half carry is carry out of bit 3; inverted borrow on subtract.
// - Carry is carry out of MSB; subtract inverts; rotates load source bit.
// - Pull-up disable turns all pull-ups off; else per-pin enables gate.
// - Edge select: rising when 1, falling when 0 on external pin.
// - Timer0 source: external pin when 1, instruction clock when 0.
// - Timer0 edge: falling when 1, rising when 0.
// - Prescaler to watchdog when 1, Timer0 when 0.
// - Rate n divides Timer0 by 2^(n+1), watchdog by 2^n.
// - Flags set on events regardless of interrupt enables; port-change flag needs per-pin change enable.
// - Global enable gates all; peripheral enable gates peripheral sources.
// - Timer0 overflow flag sticky until cleared; gated by its enable.
// - External flag set on selected edge, sticky; gated by its enable.
// - Port-change flag set on enabled port pin change, sticky; gated.
// - Peripheral enables at bits 6,3,2,1,0; bits 7,5,4 read zero.
// - Peripheral flags sit at the same bit positions as enables.
module csr_core_regs #(
  parameter int PORT_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire csr_pkg::csr_core_s core_in,
  input wire csr_pkg::csr_power_s power_in,
  input wire logic timer0_ovf_in,
  input wire logic [7:0] periph_event_in,
  input wire logic external_irq_pin_in,
  input wire logic [PORT_W-1:0] port_pins_in,
  input wire logic [PORT_W-1:0] per_pin_change_enable_in,
  input wire logic [PORT_W-1:0] per_pin_pullup_in,
  input wire logic timer_ext_clock_pin_in,
  output logic [7:0] rdata_out,
  output logic [7:0] status_out,
  output csr_pkg::csr_option_s option_out,
  output logic irq_req_out,
  output logic [PORT_W-1:0] pullup_en_out,
  output logic timer0_tick_out,
  output logic [8:0] prescale_div_out,
  output logic [8:0] direct_base_out,
  output logic [8:0] indirect_base_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] option_reg;
  logic [7:0] intctl_reg;
  logic [7:0] intctl_next;
  logic [7:0] pie_reg;
  logic [7:0] pir_reg;
  logic [7:0] pir_next;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic [PORT_W-1:0] pullup_reg;
  logic tick_reg;
  logic [8:0] div_reg;
  logic [8:0] dbase_reg;
  logic [8:0] ibase_reg;
  logic [PORT_W-1:0] port_rise;
  logic [PORT_W-1:0] port_fall;
  logic [1:0] misc_rise;
  logic [1:0] misc_fall;
  logic ext_edge;
  logic t0_edge;
  logic port_change;
  logic [6:0] low_addr;
  logic hit_status;
  logic hit_intctl;
  logic hit_option;
  logic hit_pie;
  logic hit_pir;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  csr_edge_sync #(.WIDTH(PORT_W)) u_port_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .pin_in(port_pins_in),
    .level_out(),
    .rise_out(port_rise),
    .fall_out(port_fall)
  );

  csr_edge_sync #(.WIDTH(2)) u_misc_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .pin_in({timer_ext_clock_pin_in, external_irq_pin_in}),
    .level_out(),
    .rise_out(misc_rise),
    .fall_out(misc_fall)
  );

  assign ext_edge = option_reg[6] ? misc_rise[0] : misc_fall[0];
  assign t0_edge = option_reg[4] ? misc_fall[1] : misc_rise[1];
  // Either direction counts; the flag keeps it until software clears
  assign port_change = |((port_rise | port_fall) & per_pin_change_enable_in);

  // ---------------------------------------------------------------
  // Address decode; status and interrupt control mirror in all banks
  // ---------------------------------------------------------------
  assign low_addr = core_in.addr[6:0];

  always_comb
  begin
    hit_status = 1'b0;
    hit_intctl = 1'b0;
    hit_option = 1'b0;
    hit_pie = 1'b0;
    hit_pir = 1'b0;
    if (low_addr == csr_pkg::ADDR_STATUS[6:0])
    begin
      hit_status = 1'b1;
    end
    else if (low_addr == csr_pkg::ADDR_INTCTL[6:0])
    begin
      hit_intctl = 1'b1;
    end
    else if (low_addr == csr_pkg::ADDR_OPTION[6:0] && core_in.addr[7])
    begin
      hit_option = 1'b1;
    end
    else if (core_in.addr == csr_pkg::ADDR_PIE)
    begin
      hit_pie = 1'b1;
    end
    else if (core_in.addr == csr_pkg::ADDR_PIR)
    begin
      hit_pir = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  always_comb
  begin
    status_next = status_reg;
    if (core_in.wr && hit_status)
    begin
      // Bank bits take the data; result flags only if no flag is updated
      status_next[7:5] = core_in.wdata[7:5];
      if (!(core_in.flags_upd || core_in.hc_upd || core_in.c_upd))
      begin
        status_next[2:0] = core_in.wdata[2:0];
      end
    end
    if (core_in.flags_upd)
    begin
      status_next[csr_pkg::ST_Z] = core_in.z_val;
    end
    if (core_in.hc_upd)
    begin
      status_next[csr_pkg::ST_HALF_CARRY] = core_in.hc_val;
    end
    if (core_in.c_upd)
    begin
      status_next[csr_pkg::ST_C] = core_in.c_val;
    end
    // Power flags never take written data
    if (power_in.wdt_timeout)
    begin
      status_next[csr_pkg::ST_EXPIRY_N] = 1'b0;
    end
    else if (power_in.wdt_clear || power_in.sleep)
    begin
      status_next[csr_pkg::ST_EXPIRY_N] = 1'b1;
    end
    if (power_in.sleep)
    begin
      status_next[csr_pkg::ST_SLEEP_N] = 1'b0;
    end
    else if (power_in.wdt_clear)
    begin
      status_next[csr_pkg::ST_SLEEP_N] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      status_reg <= csr_pkg::STATUS_RST;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // ---------------------------------------------------------------
  // Option register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      option_reg <= csr_pkg::OPTION_RST;
    end
    else if (core_in.wr && hit_option)
    begin
      option_reg <= core_in.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt control and peripheral flags; event set beats clear
  // ---------------------------------------------------------------
  always_comb
  begin
    intctl_next = intctl_reg;
    if (core_in.wr && hit_intctl)
    begin
      intctl_next = core_in.wdata;
    end
    if (timer0_ovf_in)
    begin
      intctl_next[csr_pkg::IC_TIMER0_FLAG] = 1'b1;
    end
    if (ext_edge)
    begin
      intctl_next[csr_pkg::IC_EXT_FLAG] = 1'b1;
    end
    if (port_change)
    begin
      intctl_next[csr_pkg::IC_PORT_FLAG] = 1'b1;
    end
  end

  always_comb
  begin
    pir_next = pir_reg;
    if (core_in.wr && hit_pir)
    begin
      pir_next = core_in.wdata & csr_pkg::PERIPH_MASK;
    end
    pir_next = pir_next | (periph_event_in & csr_pkg::PERIPH_MASK);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      intctl_reg <= csr_pkg::INTCTL_RST;
      pir_reg <= csr_pkg::PIR_RST;
    end
    else
    begin
      intctl_reg <= intctl_next;
      pir_reg <= pir_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pie_reg <= csr_pkg::PIE_RST;
    end
    else if (core_in.wr && hit_pie)
    begin
      pie_reg <= core_in.wdata & csr_pkg::PERIPH_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request, read data and derived controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= intctl_reg[csr_pkg::IC_GLOBAL_EN] &
        ((|(intctl_reg[5:3] & intctl_reg[2:0])) |
         (intctl_reg[csr_pkg::IC_PERIPH_EN] & (|(pie_reg & pir_reg))));
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_reg <= 8'h00;
    end
    else if (hit_status)
    begin
      rdata_reg <= status_reg;
    end
    else if (hit_intctl)
    begin
      rdata_reg <= intctl_reg;
    end
    else if (hit_option)
    begin
      rdata_reg <= option_reg;
    end
    else if (hit_pie)
    begin
      rdata_reg <= pie_reg;
    end
    else if (hit_pir)
    begin
      rdata_reg <= pir_reg;
    end
    else
    begin
      rdata_reg <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pullup_reg <= '0;
      tick_reg <= 1'b0;
      div_reg <= 9'h001;
      dbase_reg <= 9'h000;
      ibase_reg <= 9'h000;
    end
    else
    begin
      pullup_reg <= option_reg[7] ? '0 : per_pin_pullup_in;
      // Internal source ticks every instruction cycle
      tick_reg <= option_reg[5] ? t0_edge : 1'b1;
      // Timer0 sees 2^(n+1); watchdog 2^n, so 1:1 only via watchdog
      div_reg <= option_reg[3] ? (9'h001 << option_reg[2:0]) :
        (9'h002 << option_reg[2:0]);
      dbase_reg <= {status_reg[6:5], 7'h00};
      ibase_reg <= {status_reg[7], 8'h00};
    end
  end

  assign rdata_out = rdata_reg;
  assign status_out = status_reg;
  assign option_out = option_reg;
  assign irq_req_out = irq_reg;
  assign pullup_en_out = pullup_reg;
  assign timer0_tick_out = tick_reg;
  assign prescale_div_out = div_reg;
  assign direct_base_out = dbase_reg;
  assign indirect_base_out = ibase_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  flag_write_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    core_in.flags_upd |=> status_reg[2] == $past(core_in.z_val))
    else $error("zero flag not from result");
  power_ro_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !power_in.wdt_clear && !power_in.sleep && !power_in.wdt_timeout
    |=> $stable(status_reg[4:3]))
    else $error("power flags changed by write");
  expiry_clear_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    power_in.wdt_timeout |=> !status_reg[4])
    else $error("expiry flag not cleared");
  sleep_flag_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    power_in.sleep |=> !status_reg[3] && status_reg[4] == !$past(power_in.wdt_timeout))
    else $error("sleep flags wrong");
  bank_base_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ##1 direct_base_out == {$past(status_reg[6:5]), 7'h00})
    else $error("direct bank base wrong");
  timer_flag_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    timer0_ovf_in |=> intctl_reg[2] ##1 intctl_reg[2] || $past(core_in.wr))
    else $error("timer flag lost");
  pie_zero_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (pie_reg & ~csr_pkg::PERIPH_MASK) == 8'h00)
    else $error("reserved enable bits set");
  irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !intctl_reg[7] |=> !irq_req_out)
    else $error("request without global enable");
  periph_flag_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    periph_event_in[6] |=> pir_reg[6])
    else $error("peripheral flag lost");
endmodule // csr_core_regs

// [verilog/csr_pkg.sv]
package csr_pkg;
  // ---------------------------------------------------------------
  // Register offsets (core data address, low byte of bank image)
  // ---------------------------------------------------------------
  localparam logic [8:0] ADDR_STATUS = 9'h003;
  localparam logic [8:0] ADDR_INTCTL = 9'h00b;
  localparam logic [8:0] ADDR_OPTION = 9'h081;
  localparam logic [8:0] ADDR_PIE = 9'h08c;
  localparam logic [8:0] ADDR_PIR = 9'h00c;
  localparam logic [6:0] ADDR_LOW_MASK = 7'h7f;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ST_INDIRECT_BANK = 7;
  localparam int ST_DIRECT_BANK_LO = 5;
  localparam int ST_EXPIRY_N = 4;
  localparam int ST_SLEEP_N = 3;
  localparam int ST_Z = 2;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_C = 0;
  localparam int IC_GLOBAL_EN = 7;
  localparam int IC_PERIPH_EN = 6;
  localparam int IC_TIMER0_EN = 5;
  localparam int IC_EXT_EN = 4;
  localparam int IC_PORT_EN = 3;
  localparam int IC_TIMER0_FLAG = 2;
  localparam int IC_EXT_FLAG = 1;
  localparam int IC_PORT_FLAG = 0;
  localparam logic [7:0] PERIPH_MASK = 8'h4f;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] PIE_RST = 8'h00;
  localparam logic [7:0] PIR_RST = 8'h00;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic flags_upd;
    logic z_val;
    logic hc_val;
    logic c_val;
    logic hc_upd;
    logic c_upd;
  } csr_core_s;
  typedef struct packed {
    logic wdt_clear;
    logic sleep;
    logic wdt_timeout;
  } csr_power_s;
  typedef struct packed {
    logic pullup_disable;
    logic ext_irq_edge_sel;
    logic timer0_clk_src;
    logic timer0_edge_sel;
    logic prescaler_assign;
    logic [2:0] prescaler_rate;
  } csr_option_s;
endpackage : csr_pkg

// [verilog/csr_edge_sync.sv]
module csr_edge_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  // ---------------------------------------------------------------
  // Three-stage sampler; change counts once stages two and three agree
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] stable_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Held while the two late stages disagree, so a one-cycle glitch is lost
      stable_reg <= (s2_reg & s3_reg) | (stable_reg & (s2_reg | s3_reg));
    end
  end

  assign level_out = stable_reg;
  assign rise_out = s2_reg & s3_reg & ~stable_reg;
  assign fall_out = ~s2_reg & ~s3_reg & stable_reg;
endmodule // csr_edge_sync

// [tb/csr_core_model.sv]
module csr_core_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] rdata_in,
  output csr_pkg::csr_core_s core_out,
  output csr_pkg::csr_power_s power_out,
  output logic timer0_ovf_out,
  output logic [7:0] periph_event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Core datapath: one instruction per call
  // ---------------------------------------------------------------
  initial
  begin
    core_out = '0;
    power_out = '0;
    timer0_ovf_out = 1'b0;
    periph_event_out = 8'h00;
  end
  task automatic put(input csr_pkg::csr_core_s c);
    @(posedge clk_sys_in);
    core_out <= c;
    @(posedge clk_sys_in);
    core_out <= '0;
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    put('{addr: a, wr: 1'b1, wdata: d, default: '0});
  endtask
  // Address held two edges, so the registered read data has settled
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    core_out.addr <= a;
    repeat (2) @(posedge clk_sys_in);
    #1;
    d = rdata_in;
  endtask
  // Subtract adds the two's complement, so carries read as inverted borrows
  task automatic alu(input logic [7:0] a, input logic [7:0] b, input logic sub,
                     input logic to_st, input logic [7:0] wd);
    logic [7:0] bb;
    logic [8:0] sum;
    logic [4:0] nib;
    bb = sub ? ~b : b;
    sum = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    put('{addr: to_st ? csr_pkg::ADDR_STATUS : 9'h020, wr: to_st, wdata: wd,
          flags_upd: 1'b1, z_val: (sum[7:0] == 8'h00), hc_val: nib[4], c_val: sum[8],
          hc_upd: 1'b1, c_upd: 1'b1});
  endtask
  // Rotates load carry from the bit shifted out and leave the other flags
  task automatic rot(input logic [7:0] v, input logic left);
    put('{addr: 9'h020, c_val: left ? v[7] : v[0], c_upd: 1'b1, default: '0});
  endtask
  task automatic ev(input csr_pkg::csr_power_s p, input logic o, input logic [7:0] e);
    @(posedge clk_sys_in);
    power_out <= p;
    timer0_ovf_out <= o;
    periph_event_out <= e;
    @(posedge clk_sys_in);
    power_out <= '0;
    timer0_ovf_out <= 1'b0;
    periph_event_out <= 8'h00;
    #1;
  endtask
endmodule // csr_core_model

// [tb/test_core_status_option_irq_regs.sv]
module test_core_status_option_irq_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic clk_sys_in, reset_n_in, ext_pin, tmr_pin, ovf, irq, tick;
  logic [7:0] port_pins, chg_en, pullup_in, pev, rdata, status, pull_en;
  logic [8:0] div, dbase, ibase;
  csr_pkg::csr_core_s core;
  csr_pkg::csr_power_s power;
  csr_pkg::csr_option_s option;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  csr_core_model model (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .core_out(core),
    .power_out(power), .timer0_ovf_out(ovf), .periph_event_out(pev));
  csr_core_regs #(.PORT_W(8)) dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .core_in(core), .power_in(power), .timer0_ovf_in(ovf), .periph_event_in(pev),
    .external_irq_pin_in(ext_pin), .port_pins_in(port_pins),
    .per_pin_change_enable_in(chg_en), .per_pin_pullup_in(pullup_in),
    .timer_ext_clock_pin_in(tmr_pin), .rdata_out(rdata), .status_out(status),
    .option_out(option), .irq_req_out(irq), .pullup_en_out(pull_en),
    .timer0_tick_out(tick), .prescale_div_out(div), .direct_base_out(dbase),
    .indirect_base_out(ibase));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("CHECK FAILED %0t run hung", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] v;
    model.rd(a, v);
    chk({1'b0, v}, {1'b0, exp}, msg);
  endtask
  task automatic alu_chk(input logic [7:0] a, input logic [7:0] b, input logic s,
                         input logic [2:0] exp);
    model.alu(a, b, s, 1'b0, 8'h00);
    chk({6'h00, status[2:0]}, {6'h00, exp}, "alu flags");
  endtask
  task automatic tick_count(input logic lvl, input int exp);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    tmr_pin <= lvl;
    repeat (12)
    begin
      @(posedge clk_sys_in);
      #1;
      if (tick === 1'b1)
        n++;
    end
    chk(9'(n), 9'(exp), "tick count");
  endtask
  task automatic opt(input logic [7:0] v);
    model.wr(csr_pkg::ADDR_OPTION, v);
    settle(3);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({4'h0, status[7:3]}, 9'h003, "status reset");
    chk({1'b0, option}, 9'h0ff, "option reset");
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h00, "intctl reset");
    rd_chk(csr_pkg::ADDR_PIE, 8'h00, "pie reset");
    rd_chk(9'h020, 8'h00, "unmapped read");
  endtask
  task automatic t_status();
    model.wr(csr_pkg::ADDR_STATUS, 8'h00);
    chk({1'b0, status}, 9'h018, "status ro bits");
    for (int k = 0; k < 8; k++)
    begin
      model.wr(csr_pkg::ADDR_STATUS, {k[2:0], 5'h07});
      settle(2);
      chk({1'b0, status}, {1'b0, k[2:0], 5'h1f}, "status write");
      chk(dbase, {k[1:0], 7'h00}, "direct bank");
      chk(ibase, {k[2], 8'h00}, "indirect bank");
    end
    model.alu(8'h00, 8'h00, 1'b0, 1'b1, 8'h07);
    chk({1'b0, status}, 9'h01c, "flag write masked");
  endtask
  task automatic t_alu();
    alu_chk(8'hff, 8'h01, 1'b0, 3'b111);
    alu_chk(8'h03, 8'h05, 1'b1, 3'b000);
    alu_chk(8'h08, 8'h08, 1'b0, 3'b010);
    alu_chk(8'h10, 8'h01, 1'b1, 3'b001);
    alu_chk(8'h80, 8'h80, 1'b0, 3'b101);
    model.rot(8'h80, 1'b0);
    chk({6'h00, status[2:0]}, 9'h004, "rotate right");
    model.rot(8'h80, 1'b1);
    chk({6'h00, status[2:0]}, 9'h005, "rotate left");
  endtask
  task automatic t_power();
    model.ev(3'b010, 1'b0, 8'h00);
    chk({7'h00, status[4:3]}, 9'h002, "sleep");
    model.wr(csr_pkg::ADDR_STATUS, 8'h18);
    chk({7'h00, status[4:3]}, 9'h002, "ro after sleep");
    model.ev(3'b001, 1'b0, 8'h00);
    chk({7'h00, status[4:3]}, 9'h000, "timeout");
    model.ev(3'b100, 1'b0, 8'h00);
    chk({7'h00, status[4:3]}, 9'h003, "wdt clear");
  endtask
  task automatic t_option();
    for (int k = 0; k < 16; k++)
    begin
      opt({4'hf, k[3:0]});
      chk(div, k[3] ? 9'(1 << k[2:0]) : 9'(2 << k[2:0]), "prescale");
    end
    opt(8'h7f);
    chk({1'b0, pull_en}, 9'h0a5, "pullups on");
    opt(8'hff);
    chk({1'b0, pull_en}, 9'h000, "pullups off");
    opt(8'hdf);
    chk({8'h00, tick}, 9'h001, "internal tick");
    opt(8'hef);
    tick_count(1'b1, 1);
    tick_count(1'b0, 0);
    opt(8'hff);
    tick_count(1'b1, 0);
    tick_count(1'b0, 1);
  endtask
  // Pin edge to flag takes four edges, so each pin-edge set-flag check waits four first, each ignored-edge check eight
  task automatic t_core_irq();
    model.wr(csr_pkg::ADDR_INTCTL, 8'h00);
    model.ev(3'b000, 1'b1, 8'h00);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h04, "ovf flag");
    chk({8'h00, irq}, 9'h000, "masked");
    model.wr(csr_pkg::ADDR_INTCTL, 8'ha4);
    settle(2);
    chk({8'h00, irq}, 9'h001, "ovf irq");
    model.wr(csr_pkg::ADDR_INTCTL, 8'h24);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h24, "flag sticky");
    chk({8'h00, irq}, 9'h000, "global off");
    model.wr(csr_pkg::ADDR_INTCTL, 8'h90);
    @(posedge clk_sys_in) ext_pin <= 1'b1;
    settle(4);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h92, "rising");
    chk({8'h00, irq}, 9'h001, "ext irq");
    model.wr(csr_pkg::ADDR_INTCTL, 8'h90);
    @(posedge clk_sys_in) ext_pin <= 1'b0;
    settle(8);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h90, "falling ignored");
    opt(8'hbf);
    @(posedge clk_sys_in) ext_pin <= 1'b1;
    settle(8);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h90, "rising ignored");
    @(posedge clk_sys_in) ext_pin <= 1'b0;
    settle(4);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h92, "falling");
  endtask
  task automatic t_port();
    @(posedge clk_sys_in) chg_en <= 8'h01;
    model.wr(csr_pkg::ADDR_INTCTL, 8'h88);
    @(posedge clk_sys_in) port_pins <= 8'h02;
    settle(8);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h88, "pin not enabled");
    @(posedge clk_sys_in) port_pins <= 8'h03;
    settle(4);
    rd_chk(csr_pkg::ADDR_INTCTL, 8'h89, "port change");
    chk({8'h00, irq}, 9'h001, "port irq");
  endtask
  task automatic t_periph();
    model.wr(csr_pkg::ADDR_INTCTL, 8'h00);
    model.wr(csr_pkg::ADDR_PIE, 8'hff);
    rd_chk(csr_pkg::ADDR_PIE, 8'h4f, "pie bits");
    rd_chk(9'h18c, 8'h00, "pie not in bank 3");
    model.ev(3'b000, 1'b0, 8'hff);
    rd_chk(csr_pkg::ADDR_PIR, 8'h4f, "pir bits");
    chk({8'h00, irq}, 9'h000, "all off");
    model.wr(csr_pkg::ADDR_INTCTL, 8'h80);
    settle(2);
    chk({8'h00, irq}, 9'h000, "periph gate");
    model.wr(csr_pkg::ADDR_INTCTL, 8'hc0);
    settle(2);
    chk({8'h00, irq}, 9'h001, "periph irq");
    model.wr(csr_pkg::ADDR_PIE, 8'h00);
    settle(2);
    chk({8'h00, irq}, 9'h000, "enables off");
  endtask
  initial
  begin
    reset_n_in = 1'b0;
    ext_pin = 1'b0;
    tmr_pin = 1'b0;
    port_pins = 8'h00;
    chg_en = 8'h00;
    pullup_in = 8'ha5;
    repeat (12) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    settle(2);
    t_reset();
    t_status();
    t_alu();
    t_power();
    t_option();
    t_core_irq();
    t_port();
    t_periph();
    end_sim();
  end
endmodule // test_core_status_option_irq_regs
